// ===== inc/flash_cycle_if.sv
`timescale 1ns/1ps
`default_nettype none
interface flash_cycle_if;
    import flash_host_pkg::*;
    logic start;
    bus_op_t op;
    logic [21:0] addr;
    logic [15:0] wdata;
    logic done;
    logic [15:0] rdata;
    modport master (output start, output op, output addr, output wdata, input done, input rdata);
    modport engine (input start, input op, input addr, input wdata, output done, output rdata);
endinterface
`default_nettype wire

// ===== inc/flash_host_pkg.sv
`default_nettype none
package flash_host_pkg;
    // Avalon register map (byte addresses, word aligned)
    localparam logic [3:0] CTRL_OFFSET = 4'h0;
    localparam logic [3:0] ADDR_OFFSET = 4'h4;
    localparam logic [3:0] WDATA_OFFSET = 4'h8;
    localparam logic [3:0] STATUS_OFFSET = 4'hC;
    // Command register bit fields
    localparam int CMD_BIT = 0;
    localparam int READ_BIT = 1;
    localparam int WIDE_BIT = 2;
    localparam int ACCEL_BIT = 3;
    localparam int RESET_BIT = 4;
    localparam int BYPASS_BIT = 5;
    localparam int CYCLES_LSB = 8;
    // Status register bit fields
    localparam int BUSY_BIT = 0;
    localparam int RDY_BIT = 1;
    localparam int INRST_BIT = 2;
    localparam int RDATA_LSB = 16;
    // Timing (ns) and derived cycle counts at 40 ns
    localparam int CLK_NS = 40;
    localparam int ACCESS_NS = 70;
    localparam int SETUP_NS = 35;
    localparam int WRITE_PULSE_NS = 35;
    localparam int RECOVER_NS = 30;
    localparam int RESET_PULSE_NS = 500;
    localparam int RESET_RECOVERY_NS = 200;
    localparam int READY_WAIT_NS = 20000;
    localparam logic [15:0] ACCESS_CYC = 16'((ACCESS_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [15:0] SETUP_CYC = 16'((SETUP_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [15:0] WPULSE_CYC = 16'((WRITE_PULSE_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [15:0] RECOVER_CYC = 16'((RECOVER_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [15:0] RESET_PULSE_CYC = 16'((RESET_PULSE_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [15:0] RESET_RECOVERY_CYC = 16'((RESET_RECOVERY_NS + CLK_NS - 1) / CLK_NS);
    localparam int READY_WAIT_CYC = (READY_WAIT_NS + CLK_NS - 1) / CLK_NS;
    // Normal and bypass program sequence lengths
    localparam logic [2:0] NORMAL_PROG_CYCLES = 3'h4;
    localparam logic [2:0] BYPASS_PROG_CYCLES = 3'h2;
    typedef enum logic [1:0] {
        OP_NONE,
        OP_WRITE,
        OP_READ
    } bus_op_t;
endpackage
`default_nettype wire

// ===== logic/flash_cycle_engine.sv
`timescale 1ns/1ps
`default_nettype none
module flash_cycle_engine (
    input wire logic clk,
    input wire logic rst_b,
    flash_cycle_if.engine cyc,
    input wire logic wide,
    input wire logic hold_off,
    output logic chip_sel_n,
    output logic out_en_n,
    output logic wr_en_n,
    output logic [20:0] addr_out,
    output logic [15:0] dq_out,
    output logic [15:0] dq_oe,
    input wire logic [15:0] dq_in
);
    import flash_host_pkg::*;
    typedef enum logic [2:0] {S_IDLE, S_SETUP, S_PULSE, S_RECOVER, S_READ} st_t;
    typedef struct packed {
        st_t st;
        logic [15:0] cnt;
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic [20:0] a;
        logic [15:0] d;
        logic [15:0] doe;
        logic [15:0] rd;
        logic done;
    } eng_t;
    eng_t s_q, s_d;
    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        case (s_q.st)
            S_IDLE: begin
                s_d.ce_n = 1'b1;
                s_d.oe_n = 1'b1;
                s_d.we_n = 1'b1;
                s_d.doe = 16'h0000;
                if (cyc.start && !hold_off && cyc.op != OP_NONE) begin
                    s_d.a = cyc.addr[21:1];
                    s_d.ce_n = 1'b0;
                    s_d.cnt = 16'h0000;
                    if (wide) begin
                        s_d.a = cyc.addr[20:0];
                    end
                    if (cyc.op == OP_WRITE) begin
                        // Byte mode uses top data line as lowest address bit
                        s_d.d = wide ? cyc.wdata : {cyc.addr[0], 7'h00, cyc.wdata[7:0]};
                        s_d.doe = wide ? 16'hFFFF : 16'h80FF;
                        s_d.st = S_SETUP;
                    end else begin
                        s_d.oe_n = 1'b0;
                        s_d.d = {cyc.addr[0], 15'h0000};
                        s_d.doe = wide ? 16'h0000 : 16'h8000;
                        s_d.st = S_READ;
                    end
                end
            end
            S_SETUP: begin
                s_d.cnt = s_q.cnt + 16'h0001;
                if (s_q.cnt + 16'h0001 >= SETUP_CYC) begin
                    s_d.we_n = 1'b0;
                    s_d.cnt = 16'h0000;
                    s_d.st = S_PULSE;
                end
            end
            S_PULSE: begin
                s_d.cnt = s_q.cnt + 16'h0001;
                if (s_q.cnt + 16'h0001 >= WPULSE_CYC) begin
                    s_d.we_n = 1'b1;
                    s_d.cnt = 16'h0000;
                    s_d.st = S_RECOVER;
                end
            end
            S_RECOVER: begin
                s_d.cnt = s_q.cnt + 16'h0001;
                if (s_q.cnt + 16'h0001 >= RECOVER_CYC) begin
                    s_d.ce_n = 1'b1;
                    s_d.doe = 16'h0000;
                    s_d.done = 1'b1;
                    s_d.st = S_IDLE;
                end
            end
            S_READ: begin
                s_d.cnt = s_q.cnt + 16'h0001;
                // Full chip-select access time each read, covers standby and sleep exit
                if (s_q.cnt + 16'h0001 >= ACCESS_CYC + 16'h0001) begin
                    s_d.rd = wide ? dq_in : {8'h00, dq_in[7:0]};
                    s_d.ce_n = 1'b1;
                    s_d.oe_n = 1'b1;
                    s_d.doe = 16'h0000;
                    s_d.done = 1'b1;
                    s_d.st = S_IDLE;
                end
            end
            default: s_d.st = S_IDLE;
        endcase
        if (hold_off) begin
            s_d.st = S_IDLE;
            s_d.ce_n = 1'b1;
            s_d.oe_n = 1'b1;
            s_d.we_n = 1'b1;
            s_d.doe = 16'h0000;
        end
    end
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_q <= '{st: S_IDLE, cnt: 16'h0000, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, a: 21'h000000,
                     d: 16'h0000, doe: 16'h0000, rd: 16'h0000, done: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end
    assign chip_sel_n = s_q.ce_n;
    assign out_en_n = s_q.oe_n;
    assign wr_en_n = s_q.we_n;
    assign addr_out = s_q.a;
    assign dq_out = s_q.d;
    assign dq_oe = s_q.doe;
    assign cyc.done = s_q.done;
    assign cyc.rdata = s_q.rd;
endmodule // flash_cycle_engine
`default_nettype wire

// ===== logic/flash_host_ctrl.sv
// The register addresses and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module flash_host_ctrl #(
    parameter int READY_WAIT = flash_host_pkg::READY_WAIT_CYC
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic chip_sel_n,
    output logic out_en_n,
    output logic wr_en_n,
    output logic flash_reset_n,
    output logic width_sel,
    output logic accelerated_program,
    output logic [20:0] flash_addr,
    output logic [15:0] dq_out,
    output logic [15:0] dq_oe,
    input wire logic [15:0] dq_in,
    input wire logic ready_busy_n
);
    import flash_host_pkg::*;

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef enum logic [1:0] {H_IDLE, H_ISSUE, H_WAIT} host_st_t;
    typedef struct packed {
        host_st_t st;
        logic wide;
        logic accel;
        logic bypass;
        logic [21:0] addr;
        logic [15:0] wdata;
        logic [15:0] rdata;
        logic is_read;
        logic [2:0] left;
        logic [2:0] idx;
        logic rst_req;
        logic ack;
    } host_t;
    host_t s_q, s_d;

    flash_cycle_if cyc ();
    logic in_reset;
    logic busy;
    logic bus_access;

    // ----------------------------------------
    // Sub-blocks
    // ----------------------------------------
    flash_cycle_engine u_engine (
        .clk(clk),
        .rst_b(rst_b),
        .cyc(cyc),
        .wide(s_q.wide),
        .hold_off(in_reset),
        .chip_sel_n(chip_sel_n),
        .out_en_n(out_en_n),
        .wr_en_n(wr_en_n),
        .addr_out(flash_addr),
        .dq_out(dq_out),
        .dq_oe(dq_oe),
        .dq_in(dq_in)
    );

    flash_reset_ctrl #(
        .READY_WAIT(READY_WAIT)
    ) u_reset (
        .clk(clk),
        .rst_b(rst_b),
        .req(s_q.rst_req),
        .ready_busy_n(ready_busy_n),
        .flash_reset_n(flash_reset_n),
        .in_reset(in_reset)
    );

    assign busy = (s_q.st != H_IDLE);
    assign bus_access = avs_read || avs_write;

    // ----------------------------------------
    // Control
    // ----------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.ack = 1'b0;
        s_d.rst_req = 1'b0;
        cyc.start = 1'b0;
        cyc.op = OP_NONE;
        cyc.addr = s_q.addr;
        cyc.wdata = s_q.wdata;
        case (s_q.st)
            H_IDLE: begin
                if (avs_write && !s_q.ack) begin
                    s_d.ack = 1'b1;
                    if (avs_address == CTRL_OFFSET) begin
                        if (avs_byteenable[0]) begin
                            s_d.wide = avs_writedata[WIDE_BIT];
                            // High voltage only while programming is requested
                            s_d.accel = avs_writedata[ACCEL_BIT] && !avs_writedata[READ_BIT];
                            s_d.bypass = avs_writedata[BYPASS_BIT];
                            s_d.is_read = avs_writedata[READ_BIT];
                            if (avs_writedata[RESET_BIT]) begin
                                s_d.rst_req = 1'b1;
                                s_d.accel = 1'b0;
                            end else if (avs_writedata[CMD_BIT]) begin
                                s_d.st = H_ISSUE;
                                s_d.idx = 3'h0;
                                if (avs_writedata[READ_BIT]) begin
                                    s_d.left = 3'h1;
                                end else if (avs_writedata[BYPASS_BIT] || avs_writedata[ACCEL_BIT]) begin
                                    s_d.left = BYPASS_PROG_CYCLES;
                                end else if (avs_byteenable[1] && avs_writedata[CYCLES_LSB +: 3] != 3'h0) begin
                                    // Raw count for unlock, erase, suspend, id entry
                                    s_d.left = avs_writedata[CYCLES_LSB +: 3];
                                end else begin
                                    s_d.left = NORMAL_PROG_CYCLES;
                                end
                            end
                        end
                    end else if (avs_address == ADDR_OFFSET) begin
                        s_d.addr = avs_writedata[21:0];
                    end else if (avs_address == WDATA_OFFSET) begin
                        s_d.wdata = avs_writedata[15:0];
                    end
                end else if (avs_read && !s_q.ack) begin
                    s_d.ack = 1'b1;
                end
            end
            H_ISSUE: begin
                if (!in_reset) begin
                    cyc.start = 1'b1;
                    cyc.op = s_q.is_read ? OP_READ : OP_WRITE;
                    s_d.st = H_WAIT;
                end
            end
            H_WAIT: begin
                if (in_reset) begin
                    // Aborted sequence; software must reissue it
                    s_d.st = H_IDLE;
                end else if (cyc.done) begin
                    if (s_q.is_read) begin
                        s_d.rdata = cyc.rdata;
                    end
                    s_d.idx = s_q.idx + 3'h1;
                    if (s_q.left == 3'h1) begin
                        s_d.st = H_IDLE;
                        // High voltage off as soon as the program sequence ends
                        s_d.accel = 1'b0;
                    end else begin
                        s_d.left = s_q.left - 3'h1;
                        s_d.st = H_ISSUE;
                    end
                end
            end
            default: s_d.st = H_IDLE;
        endcase
        // Status polls are answered while a sequence runs
        if (avs_read && !s_q.ack) begin
            s_d.ack = 1'b1;
        end
        if (!bus_access) begin
            s_d.ack = 1'b0;
        end
        if (in_reset) begin
            s_d.accel = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_q <= '{st: H_IDLE, wide: 1'b1, accel: 1'b0, bypass: 1'b0, addr: 22'h000000,
                     wdata: 16'h0000, rdata: 16'h0000, is_read: 1'b0, left: 3'h0, idx: 3'h0,
                     rst_req: 1'b0, ack: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------
    // Avalon answer
    // ----------------------------------------
    always_comb begin
        avs_readdata = 32'h00000000;
        if (avs_address == CTRL_OFFSET) begin
            avs_readdata[WIDE_BIT] = s_q.wide;
            avs_readdata[ACCEL_BIT] = s_q.accel;
            avs_readdata[BYPASS_BIT] = s_q.bypass;
            avs_readdata[READ_BIT] = s_q.is_read;
        end else if (avs_address == ADDR_OFFSET) begin
            avs_readdata[21:0] = s_q.addr;
        end else if (avs_address == WDATA_OFFSET) begin
            avs_readdata[15:0] = s_q.wdata;
        end else if (avs_address == STATUS_OFFSET) begin
            avs_readdata[BUSY_BIT] = busy;
            avs_readdata[RDY_BIT] = ready_busy_n;
            avs_readdata[INRST_BIT] = in_reset;
            avs_readdata[RDATA_LSB +: 16] = s_q.rdata;
        end
    end
    // Writes stall while a sequence runs; reads never stall once acked
    assign avs_waitrequest = bus_access && !s_q.ack;

    assign width_sel = s_q.wide;
    assign accelerated_program = s_q.accel;
endmodule // flash_host_ctrl
`default_nettype wire

// ===== logic/flash_reset_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module flash_reset_ctrl #(
    parameter int READY_WAIT = flash_host_pkg::READY_WAIT_CYC
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic req,
    input wire logic ready_busy_n,
    output logic flash_reset_n,
    output logic in_reset
);
    import flash_host_pkg::*;
    typedef enum logic [1:0] {R_IDLE, R_PULSE, R_WAIT, R_RECOVER} rst_st_t;
    typedef struct packed {
        rst_st_t st;
        logic [31:0] cnt;
    } rc_t;
    rc_t s_q, s_d;
    always_comb begin
        s_d = s_q;
        case (s_q.st)
            R_IDLE: begin
                if (req) begin
                    s_d.st = R_PULSE;
                    s_d.cnt = 32'h00000000;
                end
            end
            R_PULSE: begin
                s_d.cnt = s_q.cnt + 32'h00000001;
                if (s_q.cnt + 32'h00000001 >= 32'(RESET_PULSE_CYC)) begin
                    s_d.st = R_WAIT;
                    s_d.cnt = 32'h00000000;
                end
            end
            R_WAIT: begin
                s_d.cnt = s_q.cnt + 32'h00000001;
                // Busy means an aborted algorithm still unwinding
                if (ready_busy_n || s_q.cnt >= 32'(READY_WAIT)) begin
                    s_d.st = R_RECOVER;
                    s_d.cnt = 32'h00000000;
                end
            end
            R_RECOVER: begin
                s_d.cnt = s_q.cnt + 32'h00000001;
                if (s_q.cnt + 32'h00000001 >= 32'(RESET_RECOVERY_CYC)) begin
                    s_d.st = R_IDLE;
                end
            end
            default: s_d.st = R_IDLE;
        endcase
    end
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_q <= '{st: R_IDLE, cnt: 32'h00000000};
        end else begin
            s_q <= s_d;
        end
    end
    assign flash_reset_n = (s_q.st != R_PULSE);
    assign in_reset = (s_q.st != R_IDLE);
endmodule // flash_reset_ctrl
`default_nettype wire

// ===== tb/flash_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
module flash_dev_model #(
    parameter logic [15:0] ERASE_CODE = 16'h0030,
    parameter int BUSY_CYC = 200,
    parameter int RESET_CYC = 10
) (
    input wire logic clk,
    input wire logic chip_sel_n,
    input wire logic out_en_n,
    input wire logic wr_en_n,
    input wire logic flash_reset_n,
    input wire logic width_sel,
    input wire logic [20:0] flash_addr,
    input wire logic [15:0] dq_out,
    output logic [15:0] dq_in,
    output logic ready_busy_n
);
    logic [7:0] mem [0:15];
    logic [15:0] last_q = 16'h0000;
    logic we_q = 1'b1;
    int busy = 0;
    logic [3:0] ba;
    assign ba = {flash_addr[2:0], width_sel ? 1'b0 : dq_out[15]};
    assign ready_busy_n = (busy == 0);
    // --------------------------------
    // Read path, released lines toggle
    // --------------------------------
    always_comb begin
        if (!chip_sel_n && !out_en_n && flash_reset_n) begin
            dq_in = width_sel ? {mem[ba + 4'h1], mem[ba]} : {~last_q[15:8], mem[ba]};
        end else begin
            dq_in = ~last_q;
        end
    end
    initial for (int i = 0; i < 16; i++) mem[i] = 8'hFF;
    always @(posedge clk) begin
        last_q <= dq_in;
        we_q <= wr_en_n;
        if (busy > 0) busy <= busy - 1;
        if (!flash_reset_n && busy > RESET_CYC) busy <= RESET_CYC;
        if (flash_reset_n && !we_q && wr_en_n && !chip_sel_n && out_en_n) begin
            if (dq_out == ERASE_CODE) begin
                busy <= BUSY_CYC;
                for (int i = 0; i < 16; i++) mem[i] <= 8'hFF;
            end else begin
                mem[ba] <= dq_out[7:0];
                if (width_sel) mem[ba + 4'h1] <= dq_out[15:8];
            end
        end
    end
endmodule // flash_dev_model
`default_nettype wire

// ===== tb/flash_host_ctrl_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module flash_host_ctrl_asserts (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic chip_sel_n,
    input wire logic out_en_n,
    input wire logic wr_en_n,
    input wire logic flash_reset_n,
    input wire logic width_sel,
    input wire logic accelerated_program,
    input wire logic [15:0] dq_oe
);
    import flash_host_pkg::*;
    // --------------------------------
    // Reset pulse length counter
    // --------------------------------
    logic [15:0] lo_q;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            lo_q <= 16'h0000;
        end else if (!flash_reset_n) begin
            lo_q <= lo_q + 16'h0001;
        end else begin
            lo_q <= 16'h0000;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence we_pulse;
        (!chip_sel_n && out_en_n) ##1 (wr_en_n && !chip_sel_n) ##1 chip_sel_n;
    endsequence
    chk_cmd_strobes: assert property (!wr_en_n |-> !chip_sel_n && out_en_n)
        else $error("write strobe without select or with output enable");
    chk_write_pulse: assert property ($fell(wr_en_n) |-> we_pulse)
        else $error("write pulse shape wrong");
    chk_drive_dir: assert property ((|dq_oe[14:0] || (dq_oe[15] && width_sel)) |-> out_en_n)
        else $error("data driven while output enable low");
    chk_accel_only: assert property (accelerated_program |-> flash_reset_n && out_en_n)
        else $error("high voltage outside programming");
    chk_reset_quiet: assert property (!flash_reset_n |-> chip_sel_n && wr_en_n)
        else $error("cycle issued during flash reset");
    chk_reset_width: assert property ($rose(flash_reset_n) |-> lo_q >= RESET_PULSE_CYC)
        else $error("flash reset pulse too short");
    chk_reset_recover: assert property ($rose(flash_reset_n) |-> chip_sel_n [*5])
        else $error("select before reset recovery");
    chk_byte_lanes: assert property (!width_sel |-> dq_oe[14:8] == 7'h00)
        else $error("upper lanes driven in byte mode");
endmodule // flash_host_ctrl_asserts
bind flash_host_ctrl flash_host_ctrl_asserts chk_i (.clk(clk), .rst_b(rst_b), .chip_sel_n(chip_sel_n),
    .out_en_n(out_en_n), .wr_en_n(wr_en_n), .flash_reset_n(flash_reset_n), .width_sel(width_sel),
    .accelerated_program(accelerated_program), .dq_oe(dq_oe));
`default_nettype wire

// ===== tb/tb_flash_host_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module tb_flash_host_ctrl;
    import flash_host_pkg::*;
    localparam logic [15:0] ERASE_CODE = 16'h0030;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic avs_waitrequest, chip_sel_n, out_en_n, wr_en_n, flash_reset_n, width_sel;
    logic accelerated_program, ready_busy_n;
    logic [20:0] flash_addr;
    logic [15:0] dq_out, dq_oe, dq_in;
    int err_total = 0;
    int total_checks = 0;
    int cyc = 0;
    int n_wr = 0;
    logic wr_q = 1'b1;
    logic accel_seen = 1'b0;
    logic [31:0] rd;
    flash_host_ctrl #(.READY_WAIT(20)) flash_host_ctrl_i (.clk, .rst_b, .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .chip_sel_n,
        .out_en_n, .wr_en_n, .flash_reset_n, .width_sel, .accelerated_program, .flash_addr, .dq_out,
        .dq_oe, .dq_in, .ready_busy_n);
    flash_dev_model #(.ERASE_CODE(ERASE_CODE)) flash_dev_model_i (.clk, .chip_sel_n, .out_en_n,
        .wr_en_n, .flash_reset_n, .width_sel, .flash_addr, .dq_out, .dq_in, .ready_busy_n);
    initial forever #20 clk = ~clk;
    // --------------------------------
    // Bus tasks and checks
    // --------------------------------
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", n, e, g);
        end
    endtask
    task automatic av_wr(input logic [3:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= 1'b1;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
        @(posedge clk);
    endtask
    task automatic av_rd(input logic [3:0] a);
        avs_address <= a;
        avs_read <= 1'b1;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        @(posedge clk);
    endtask
    task automatic cmd(input logic [31:0] c);
        int n;
        av_wr(CTRL_OFFSET, c);
        n = 0;
        do begin
            av_rd(STATUS_OFFSET);
            n++;
        end while ((rd[BUSY_BIT] !== 1'b0 || rd[INRST_BIT] !== 1'b0) && n < 400);
    endtask
    task automatic prog(input logic [21:0] a, input logic [15:0] d, input logic [31:0] c, input int cnt);
        av_wr(ADDR_OFFSET, {10'h0, a});
        av_wr(WDATA_OFFSET, {16'h0, d});
        n_wr = 0;
        cmd(c);
        chk("write cycles", 32'(cnt), 32'(n_wr));
    endtask
    task automatic frd(input logic [21:0] a, input logic w);
        av_wr(ADDR_OFFSET, {10'h0, a});
        cmd({29'h0, w, 2'b11});
        av_rd(STATUS_OFFSET);
        rd = {16'h0, rd[31:16]};
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        wr_q <= wr_en_n;
        if (wr_q === 1'b1 && wr_en_n === 1'b0) n_wr <= n_wr + 1;
        if (accelerated_program === 1'b1 && wr_en_n === 1'b0) accel_seen <= 1'b1;
        if (cyc == 20000) begin
            err_total++;
            close_out();
        end
    end
    // --------------------------------
    // Test sequence
    // --------------------------------
    initial begin
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        chk("idle pins", 32'h3E, {26'h0, chip_sel_n, out_en_n, wr_en_n, flash_reset_n, width_sel,
            accelerated_program});
        chk("idle drive", 32'h0, {16'h0, dq_oe});
        av_wr(4'h2, 32'h1234);
        av_rd(4'h2);
        chk("unmapped", 32'h0, rd);
        $display("test idle done");
        prog(22'h5, 16'hA55A, 32'h105, 1);
        frd(22'h5, 1'b1);
        chk("word", 32'hA55A, rd);
        prog(22'h6, 16'h1111, 32'h005, 4);
        prog(22'h6, 16'h2222, 32'h025, 2);
        accel_seen = 1'b0;
        prog(22'h7, 16'h3333, 32'h00D, 2);
        chk("accel seen", 32'h1, {31'h0, accel_seen});
        chk("accel off", 32'h0, {31'h0, accelerated_program});
        frd(22'h7, 1'b1);
        chk("accel data", 32'h3333, rd);
        $display("test program done");
        prog(22'h9, 16'h00C3, 32'h101, 1);
        frd(22'h9, 1'b0);
        chk("byte", 32'hC3, {24'h0, rd[7:0]});
        $display("test byte done");
        prog(22'h0, ERASE_CODE, 32'h105, 1);
        frd(22'h5, 1'b1);
        chk("read busy", 32'hFFFF, rd);
        chk("busy", 32'h0, {31'h0, ready_busy_n});
        av_rd(STATUS_OFFSET);
        chk("status ready", 32'h0, {31'h0, rd[RDY_BIT]});
        cmd(32'h10);
        chk("ready", 32'h1, {31'h0, ready_busy_n});
        prog(22'h5, 16'hA55A, 32'h105, 1);
        cmd(32'h10);
        frd(22'h5, 1'b1);
        chk("after reset", 32'hA55A, rd);
        $display("test reset done");
        close_out();
    end
endmodule // tb_flash_host_ctrl
`default_nettype wire
